// ### spimc_master.sv
// spimc_master: serial peripheral unit in master role with register port.
// assumes: pins resolved outside from out/oe; reg port strobes are single-cycle
// and from the bus clock domain; pin inputs are asynchronous.
`timescale 1ns/10ps

// How it works
// - Transfers start only while master_select is set, which makes the unit the master.
// - A data write in master role loads the shift register when it is empty and shifts it out.
// - The serial clock rate comes from the three rate-select and three preselect bits together.
// - In master role the unit drives the serial clock pin to clock the remote slave.
// - Data pin roles follow the single-wire pin control and bidirectional output enable bits.
// - With fault detect and select output enabled, the select pin is an output low per transfer.
// - With fault detect on and select output off, a low select input is a mode fault.
// - A mode fault clears master_select and releases every pin to input.
// - A mode fault abandons any transfer in progress and returns the unit to idle.
// - A mode fault sets the mode fault flag and requests an interrupt when enabled.
// - After a data write the unit waits two half periods (one full serial clock period) before clocking.
// - Changing format, select, fault or rate bits in master role aborts and forces idle.
module spimc_master
(
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic [spimc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [spimc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [spimc_pkg::DATA_W-1:0] reg_rdata,
  output logic                              irq,
  input  wire logic                         sck_in,
  output logic                              sck_out,
  output logic                              sck_oe,
  input  wire logic                         mosi_in,
  output logic                              mosi_out,
  output logic                              mosi_oe,
  input  wire logic                         miso_in,
  output logic                              miso_out,
  output logic                              miso_oe,
  input  wire logic                         ss_in,
  output logic                              ss_out,
  output logic                              ss_oe
);

  localparam int DW = spimc_pkg::DATA_W;
  localparam int EW = spimc_pkg::EDGE_W;

  function automatic logic hit(input logic [spimc_pkg::ADDR_W-1:0] a,
                               input logic [spimc_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // pin synchronisers, first stage read only by the second
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       sck_sync;
  logic       mosi_sync;
  logic       miso_sync;
  logic       ss_sync;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= 4'hF;
      pin_sync <= 4'hF;
    end
    else
    begin
      pin_meta <= {sck_in, mosi_in, miso_in, ss_in};
      pin_sync <= pin_meta;
    end
  end

  assign {sck_sync, mosi_sync, miso_sync, ss_sync} = pin_sync;

  // register group
  logic [DW-1:0] ctrl1;
  logic [DW-1:0] ctrl2;
  logic [DW-1:0] baud;
  logic [DW-1:0] status;
  logic [DW-1:0] mask;
  logic [DW-1:0] rx_data;
  logic [DW-1:0] next_ctrl1;
  logic [DW-1:0] next_ctrl2;
  logic [DW-1:0] next_baud;
  logic [DW-1:0] next_status;
  logic [DW-1:0] next_mask;
  logic [DW-1:0] next_rdata;

  logic master;
  logic clock_polarity;
  logic clock_phase;
  logic select_output_enable;
  logic lsbf;
  logic fault_detect_enable;
  logic bidir_oe;
  logic single_wire_pin_control;
  logic mode_fault;
  logic cfg_abort;
  logic data_write;
  logic frame_done;
  logic [DW-1:0] frame_rx;

  assign master   = ctrl1[spimc_pkg::C1_MASTER_BIT];
  assign clock_polarity     = ctrl1[spimc_pkg::C1_CLOCK_POLARITY_BIT];
  assign clock_phase     = ctrl1[spimc_pkg::C1_CLOCK_PHASE_BIT];
  assign select_output_enable     = ctrl1[spimc_pkg::C1_SELECT_OUTPUT_ENABLE_BIT];
  assign lsbf     = ctrl1[spimc_pkg::C1_LSBF_BIT];
  assign fault_detect_enable   = ctrl2[spimc_pkg::C2_FAULT_DETECT_ENABLE_BIT];
  assign bidir_oe = ctrl2[spimc_pkg::C2_BIDIR_BIT];
  assign single_wire_pin_control     = ctrl2[spimc_pkg::C2_SINGLE_WIRE_PIN_CONTROL_BIT];

  // low select input while acting as master with detection on
  assign mode_fault = master && fault_detect_enable && !select_output_enable && !ss_sync;

  assign data_write = reg_write && hit(reg_addr, spimc_pkg::DATA_ADDR) && master;

  // any change of format or rate bits in master role kills the frame
  always_comb
  begin
    logic [DW-1:0] d1;
    logic [DW-1:0] d2;
    d1 = '0;
    d2 = '0;
    cfg_abort = 1'b0;
    if (reg_write && master)
    begin
      if (hit(reg_addr, spimc_pkg::CTRL1_ADDR))
      begin
        d1 = (reg_wdata ^ ctrl1) & spimc_pkg::CTRL1_WMASK;
        cfg_abort = d1[spimc_pkg::C1_CLOCK_POLARITY_BIT] | d1[spimc_pkg::C1_CLOCK_PHASE_BIT]
                  | d1[spimc_pkg::C1_SELECT_OUTPUT_ENABLE_BIT] | d1[spimc_pkg::C1_LSBF_BIT];
      end
      if (hit(reg_addr, spimc_pkg::CTRL2_ADDR))
      begin
        d2 = (reg_wdata ^ ctrl2) & spimc_pkg::CTRL2_WMASK;
        cfg_abort = d2[spimc_pkg::C2_FAULT_DETECT_ENABLE_BIT] | d2[spimc_pkg::C2_SINGLE_WIRE_PIN_CONTROL_BIT]
                  | (d2[spimc_pkg::C2_BIDIR_BIT] & single_wire_pin_control);
      end
      if (hit(reg_addr, spimc_pkg::BAUD_ADDR))
      begin
        cfg_abort = |((reg_wdata ^ baud) & spimc_pkg::BAUD_WMASK);
      end
    end
  end

  always_comb
  begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_baud = baud;
    next_mask = mask;
    next_status = status;
    next_rdata = '0;
    if (reg_write)
    begin
      case (reg_addr)
        spimc_pkg::CTRL1_ADDR: next_ctrl1 = reg_wdata & spimc_pkg::CTRL1_WMASK;
        spimc_pkg::CTRL2_ADDR: next_ctrl2 = reg_wdata & spimc_pkg::CTRL2_WMASK;
        spimc_pkg::BAUD_ADDR:  next_baud = reg_wdata & spimc_pkg::BAUD_WMASK;
        spimc_pkg::MASK_ADDR:  next_mask = reg_wdata & spimc_pkg::STATUS_WMASK;
        default:               next_mask = mask;
      endcase
    end
    if (reg_read)
    begin
      case (reg_addr)
        spimc_pkg::CTRL1_ADDR:  next_rdata = ctrl1;
        spimc_pkg::CTRL2_ADDR:  next_rdata = ctrl2;
        spimc_pkg::BAUD_ADDR:   next_rdata = baud;
        spimc_pkg::STATUS_ADDR: next_rdata = status;
        spimc_pkg::MASK_ADDR:   next_rdata = mask;
        spimc_pkg::DATA_ADDR:   next_rdata = rx_data;
        spimc_pkg::PINS_ADDR:   next_rdata = {4'h0, pin_sync};
        default:                next_rdata = '0;
      endcase
      // read of status clears it; sets below still win
      if (hit(reg_addr, spimc_pkg::STATUS_ADDR))
      begin
        next_status = '0;
      end
    end
    if (mode_fault)
    begin
      next_ctrl1[spimc_pkg::C1_MASTER_BIT] = 1'b0;
      next_status[spimc_pkg::ST_MODE_FAULT_FLAG_BIT] = 1'b1;
    end
    if (frame_done)
    begin
      next_status[spimc_pkg::ST_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ctrl1 <= spimc_pkg::CTRL1_RESET;
      ctrl2 <= spimc_pkg::CTRL2_RESET;
      baud <= spimc_pkg::BAUD_RESET;
      status <= spimc_pkg::STATUS_RESET;
      mask <= spimc_pkg::MASK_RESET;
      reg_rdata <= '0;
    end
    else
    begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      baud <= next_baud;
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
    end
  end

  // global enable gates the masked sticky bits onto one level
  assign irq = ctrl1[spimc_pkg::C1_IRQ_EN_BIT] && |(status & mask);

  // shift engine group
  spimc_pkg::spimc_state_t state;
  spimc_pkg::spimc_state_t next_state;
  logic [DW-1:0] shreg;
  logic [DW-1:0] next_shreg;
  logic [DW-1:0] hold_buf;
  logic [DW-1:0] next_hold_buf;
  logic          hold_full;
  logic          next_hold_full;
  logic [EW-1:0] edge_idx;
  logic [EW-1:0] next_edge_idx;
  logic          sck_level;
  logic          next_sck_level;
  logic          rx_bit;
  logic          next_rx_bit;
  logic [DW-1:0] next_rx_data;
  logic          restart;
  logic          tick;
  logic          rx_pin;

  spimc_rate_gen u_rate
  (
    .clock     (clock),
    .reset     (reset),
    .restart   (restart),
    .preselect (baud[spimc_pkg::BAUD_PRE_LSB +: 3]),
    .select    (baud[spimc_pkg::BAUD_SEL_LSB +: 3]),
    .tick      (tick)
  );

  // single-wire mode receives on the shared data pin
  assign rx_pin = single_wire_pin_control ? mosi_sync : miso_sync;

  function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] sr,
                                            input logic          b,
                                            input logic          lsb_first);
    shift_in = lsb_first ? {b, sr[DW-1:1]} : {sr[DW-2:0], b};
  endfunction : shift_in

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_hold_buf = hold_buf;
    next_hold_full = hold_full;
    next_edge_idx = edge_idx;
    next_sck_level = sck_level;
    next_rx_bit = rx_bit;
    next_rx_data = rx_data;
    restart = 1'b0;
    frame_done = 1'b0;
    frame_rx = '0;
    case (state)
      spimc_pkg::SPIMC_IDLE:
      begin
        next_sck_level = clock_polarity;
        if (data_write)
        begin
          next_shreg = reg_wdata;
          next_state = spimc_pkg::SPIMC_LEAD;
          restart = 1'b1;
        end
      end
      spimc_pkg::SPIMC_LEAD:
      begin
        if (tick)
        begin
          next_state = spimc_pkg::SPIMC_SHIFT;
          next_edge_idx = '0;
        end
      end
      spimc_pkg::SPIMC_SHIFT:
      begin
        if (tick)
        begin
          next_sck_level = !sck_level;
          next_edge_idx = edge_idx + EW'(1);
          if (edge_idx[0] == clock_phase)
          begin
            next_rx_bit = rx_pin;
          end
          else if (edge_idx != '0)
          begin
            next_shreg = shift_in(shreg, rx_bit, lsbf);
          end
          if (edge_idx == EW'(spimc_pkg::HALF_EDGES - 1))
          begin
            // phase 1 samples on the last edge, so finish that shift here
            frame_rx = clock_phase ? shift_in(shreg, rx_pin, lsbf) : shift_in(shreg, rx_bit, lsbf);
            next_rx_data = frame_rx;
            frame_done = 1'b1;
            next_state = spimc_pkg::SPIMC_IDLE;
            if (hold_full)
            begin
              next_shreg = hold_buf;
              next_hold_full = 1'b0;
              next_state = spimc_pkg::SPIMC_LEAD;
              restart = 1'b1;
            end
          end
        end
      end
      default:
      begin
        next_state = spimc_pkg::SPIMC_IDLE;
      end
    endcase
    if (data_write && state != spimc_pkg::SPIMC_IDLE)
    begin
      next_hold_buf = reg_wdata;
      next_hold_full = 1'b1;
    end
    if (mode_fault || cfg_abort || !master)
    begin
      next_state = spimc_pkg::SPIMC_IDLE;
      next_hold_full = 1'b0;
      next_sck_level = cfg_abort ? reg_wdata[spimc_pkg::C1_CLOCK_POLARITY_BIT] & hit(reg_addr,
                       spimc_pkg::CTRL1_ADDR) | clock_polarity & !hit(reg_addr, spimc_pkg::CTRL1_ADDR)
                       : clock_polarity;
      frame_done = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= spimc_pkg::SPIMC_IDLE;
      shreg <= '0;
      hold_buf <= '0;
      hold_full <= 1'b0;
      edge_idx <= '0;
      sck_level <= 1'b0;
      rx_bit <= 1'b0;
      rx_data <= spimc_pkg::DATA_RESET;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      hold_buf <= next_hold_buf;
      hold_full <= next_hold_full;
      edge_idx <= next_edge_idx;
      sck_level <= next_sck_level;
      rx_bit <= next_rx_bit;
      rx_data <= next_rx_data;
    end
  end

  // pin drive; all released when not master
  always_comb
  begin
    sck_out = sck_level;
    sck_oe = master;
    mosi_out = lsbf ? shreg[0] : shreg[DW-1];
    mosi_oe = master && (!single_wire_pin_control || bidir_oe);
    miso_out = 1'b0;
    miso_oe = 1'b0;
    ss_out = (state == spimc_pkg::SPIMC_IDLE);
    ss_oe = master && fault_detect_enable && select_output_enable;
  end

endmodule : spimc_master

// ### spimc_master_monitor.sv
// spimc_master_monitor: port-level checks for the serial master control block.
// assumes: bound to spimc_master, single bus clock, reset async active high.
`timescale 1ns/10ps
module spimc_master_monitor
(
  input wire logic                         clock,
  input wire logic                         reset,
  input wire logic [spimc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [spimc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                         reg_write,
  input wire logic                         reg_read,
  input wire logic [spimc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                         irq,
  input wire logic                         sck_out,
  input wire logic                         sck_oe,
  input wire logic                         mosi_oe,
  input wire logic                         ss_in,
  input wire logic                         ss_out,
  input wire logic                         ss_oe
);
  logic [6:0]  baud_q;
  logic        fault_en_q;
  logic        lead_q;
  logic        sck_q;
  logic [15:0] since;
  logic [10:0] half;
  logic        data_wr;

  // shadow of the rate setting: half period in bus clocks
  assign half    = (11'(baud_q[6:4]) + 11'h001) << baud_q[2:0];
  assign data_wr = reg_write && reg_addr == spimc_pkg::DATA_ADDR;

  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      baud_q     <= 7'h00;
      fault_en_q <= 1'b0;
      lead_q     <= 1'b0;
      sck_q      <= 1'b0;
      since      <= 16'h0000;
    end
    else
    begin
      sck_q <= sck_out;
      if (reg_write && reg_addr == spimc_pkg::BAUD_ADDR)
        baud_q <= reg_wdata[6:0] & 7'h77;
      if (reg_write && reg_addr == spimc_pkg::CTRL2_ADDR)
        fault_en_q <= reg_wdata[spimc_pkg::C2_FAULT_DETECT_ENABLE_BIT];
      // saturate so a long idle never wraps into a false short delay
      if (data_wr && ss_out)
      begin
        since  <= 16'h0000;
        lead_q <= 1'b1;
      end
      else
      begin
        if (since != 16'hFFFF)
          since <= since + 16'h0001;
        if (sck_out != sck_q)
          lead_q <= 1'b0;
      end
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_rdata_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");

  property p_sck_quiet;
    $changed(sck_out) && !$past(reg_write) |-> !$past(ss_out);
  endproperty
  a_sck_quiet: assert property (p_sck_quiet) else $error("serial clock moved outside a frame");

  property p_half_delay;
    lead_q && !ss_out && sck_out != sck_q |-> since >= 16'(half);
  endproperty
  a_half_delay: assert property (p_half_delay) else $error("serial clock started too early");

  property p_ss_lead;
    data_wr && sck_oe && ss_out |=> !ss_out;
  endproperty
  a_ss_lead: assert property (p_ss_lead) else $error("select did not fall on data write");

  property p_abort;
    reg_write && reg_addr == spimc_pkg::BAUD_ADDR && sck_oe && !ss_out
      && (reg_wdata[6:0] & 7'h77) != baud_q |=> ss_out;
  endproperty
  a_abort: assert property (p_abort) else $error("rate change did not abort frame");

  property p_fault;
    sck_oe && fault_en_q && !ss_oe && !ss_in |-> ##[1:5] (!sck_oe && !mosi_oe && !ss_oe);
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault did not release pins");

  property p_irq_fall;
    $fell(irq) |-> $past(reg_read || reg_write);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without access");

  property p_mosi_role;
    mosi_oe |-> sck_oe;
  endproperty
  a_mosi_role: assert property (p_mosi_role) else $error("data driven without master role");

  property p_ss_role;
    ss_oe |-> sck_oe;
  endproperty
  a_ss_role: assert property (p_ss_role) else $error("select driven without master role");

  c_frame: cover property ($rose(ss_out) && $past(sck_oe));
  c_fault: cover property ($fell(sck_oe) && !ss_in);
  c_irq: cover property ($rose(irq));
endmodule : spimc_master_monitor

bind spimc_master spimc_master_monitor u_mon
(
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
  .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .ss_in(ss_in),
  .ss_out(ss_out), .ss_oe(ss_oe)
);

// ### spimc_pkg.sv
// spimc_pkg: constants shared by the serial master control logic.
// assumes: 8-bit register port, 3-bit register index, single bus clock.
package spimc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int BITS_PER_FRAME = 8;
  localparam int HALF_EDGES = 2 * BITS_PER_FRAME;
  localparam int EDGE_W = 4;
  localparam int RATE_CNT_W = 11;

  // register indices
  localparam logic [ADDR_W-1:0] CTRL1_ADDR  = 3'h0;
  localparam logic [ADDR_W-1:0] CTRL2_ADDR  = 3'h1;
  localparam logic [ADDR_W-1:0] BAUD_ADDR   = 3'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 3'h3;
  localparam logic [ADDR_W-1:0] MASK_ADDR   = 3'h4;
  localparam logic [ADDR_W-1:0] DATA_ADDR   = 3'h5;
  localparam logic [ADDR_W-1:0] PINS_ADDR   = 3'h6;

  // control 1 fields
  localparam int C1_IRQ_EN_BIT = 7;
  localparam int C1_MASTER_BIT = 4;
  localparam int C1_CLOCK_POLARITY_BIT   = 3;
  localparam int C1_CLOCK_PHASE_BIT   = 2;
  localparam int C1_SELECT_OUTPUT_ENABLE_BIT   = 1;
  localparam int C1_LSBF_BIT   = 0;

  // control 2 fields
  localparam int C2_FAULT_DETECT_ENABLE_BIT = 4;
  localparam int C2_BIDIR_BIT  = 3;
  localparam int C2_SINGLE_WIRE_PIN_CONTROL_BIT   = 0;

  // baud fields
  localparam int BAUD_PRE_LSB = 4;
  localparam int BAUD_SEL_LSB = 0;

  // status / mask fields
  localparam int ST_MODE_FAULT_FLAG_BIT = 0;
  localparam int ST_DONE_BIT = 1;

  // writable bit masks
  localparam logic [DATA_W-1:0] CTRL1_WMASK  = 8'h9F;
  localparam logic [DATA_W-1:0] CTRL2_WMASK  = 8'h19;
  localparam logic [DATA_W-1:0] BAUD_WMASK   = 8'h77;
  localparam logic [DATA_W-1:0] STATUS_WMASK = 8'h03;

  localparam logic [DATA_W-1:0] CTRL1_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] CTRL2_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] BAUD_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;

  typedef enum logic [2:0]
  {
    SPIMC_IDLE  = 3'b001,
    SPIMC_LEAD  = 3'b010,
    SPIMC_SHIFT = 3'b100
  } spimc_state_t;

endpackage : spimc_pkg

// ### spimc_rate_gen.sv
// spimc_rate_gen: half-period tick generator for the serial clock.
// assumes: restart is a one-cycle pulse from the same clock domain.
`timescale 1ns/10ps
module spimc_rate_gen
#(
  parameter int CNT_W = spimc_pkg::RATE_CNT_W
)
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       restart,
  input  wire logic [2:0] preselect,
  input  wire logic [2:0] select,
  output logic            tick
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] limit;
  logic             next_tick;

  // half period = (preselect + 1) * 2^select bus clocks
  always_comb
  begin
    limit = CNT_W'((({{(CNT_W-3){1'b0}}, preselect} + CNT_W'(1)) << select) - CNT_W'(1));
    next_tick = 1'b0;
    next_count = count + CNT_W'(1);
    if (restart)
    begin
      next_count = '0;
    end
    else if (count >= limit)
    begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule : spimc_rate_gen

// ### spimc_slave_model.sv
// spimc_slave_model: behavioural remote slave on the serial link.
// assumes: format inputs set by the bench while the slave is deselected.
`timescale 1ns/10ps
module spimc_slave_model
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output int              rx_n
);
  logic [7:0] sh;
  logic       ss_d;
  logic       mosi_d;
  int         k;
  int         n;

  // select and data seen 1 ns late: an edge that shares its time step with a
  // deselect or a reload of the master's shifter still sees the old levels
  always @(ss_n) ss_d <= #1 ss_n;
  always @(mosi) mosi_d <= #1 mosi;

  task automatic drive();
    miso = lsb_first ? tx_byte[k] : tx_byte[7 - k];
    k = (k + 1) % 8;
  endtask : drive

  initial
  begin
    miso = 1'b0;
    rx_byte = 8'h00;
    rx_n = 0;
    k = 0;
    n = 0;
    sh = 8'h00;
    ss_d = 1'b1;
    mosi_d = 1'b1;
  end

  always @(negedge ss_d)
  begin
    k = 0;
    n = 0;
    if (!clock_phase)
      drive();
  end

  // deselect drops a partial byte; stale level is inverted, not held
  always @(posedge ss_d)
  begin
    n = 0;
    miso = ~miso;
  end

  always @(sck)
    if (!ss_d)
    begin
      if ((sck != clock_polarity) ^ clock_phase)
      begin
        sh = lsb_first ? {mosi_d, sh[7:1]} : {sh[6:0], mosi_d};
        n++;
        if (n == 8)
        begin
          n = 0;
          rx_byte = sh;
          rx_n++;
        end
      end
      else
        drive();
    end
endmodule : spimc_slave_model

// ### testbench.sv
// testbench: register-port driven checks of the serial master with a slave model.
// assumes: pull-ups on the sck and mosi pins while nobody drives them; the slave drives miso and the bench drives select while ss_oe is low.
`timescale 1ns/10ps
module testbench;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
  logic       ext_ss = 1'b1;
  logic       clock_polarity = 1'b0, clock_phase = 1'b0, lsb = 1'b0;
  logic [7:0] stx = 8'h00, srx;
  logic       s_miso;
  int         srx_n;
  int         fail_count = 0;
  int         checks_done = 0;
  int         seed = 58363;
  logic [7:0] exp_q[$];
  wire        sck_w = sck_oe ? sck_out : 1'b1;
  wire        mosi_w = mosi_oe ? mosi_out : 1'b1;
  wire        miso_w = miso_oe ? miso_out : s_miso;
  wire        ss_w = ss_oe ? ss_out : ext_ss;

  always #4 clock = ~clock;

  spimc_master u_dut
  (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_in(ss_w), .ss_out(ss_out), .ss_oe(ss_oe)
  );

  spimc_slave_model u_slave
  (
    .sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .lsb_first(lsb),
    .tx_byte(stx), .miso(s_miso), .rx_byte(srx), .rx_n(srx_n)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wait_idle();
    int i;
    repeat (3) @(posedge clock);
    for (i = 0; i < 4000 && ss_out !== 1'b1; i++)
      @(posedge clock);
    #1 chk("frame end", 8'h01, {7'h00, ss_out});
  endtask : wait_idle

  task automatic xfer(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] d;
    stx = s;
    exp_q.push_back(m);
    wr(spimc_pkg::DATA_ADDR, m);
    wait_idle();
    chk("irq done", 8'h01, {7'h00, irq});
    rd(spimc_pkg::DATA_ADDR, d);
    chk("rx data", s, d);
    rd(spimc_pkg::STATUS_ADDR, d);
    chk("status", 8'h02, d);
    chk("irq clear", 8'h00, {7'h00, irq});
  endtask : xfer

  // each byte the slave completes must be the next one the master sent
  always @(srx_n)
    if (srx_n != 0)
      chk("slave rx", exp_q.pop_front(), srx);

  initial
  begin
    #400000;
    fail_count++;
    results();
  end

  initial
  begin
    logic [7:0] d, b, c2[3], oe[3];
    int a;
    c2 = '{8'h10, 8'h11, 8'h19};
    oe = '{8'h01, 8'h00, 8'h01};
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (a = 0; a < 8; a++)
      if (a != 6)
      begin
        rd(3'(a), d);
        chk("reset value", 8'h00, d);
      end
    wr(spimc_pkg::MASK_ADDR, 8'h03);
    wr(spimc_pkg::CTRL2_ADDR, 8'h10);
    wr(spimc_pkg::DATA_ADDR, 8'hA5);
    repeat (40) @(posedge clock);
    rd(spimc_pkg::STATUS_ADDR, d);
    chk("no master no frame", 8'h00, d);
    b = 8'h40;
    wr(spimc_pkg::BAUD_ADDR, b);
    for (a = 0; a < 8; a++)
    begin
      {lsb, clock_phase, clock_polarity} = 3'(a);
      wr(spimc_pkg::CTRL1_ADDR, {4'h9, clock_polarity, clock_phase, 1'b1, lsb});
      xfer(8'($random(seed)), 8'($random(seed)));
      b = {1'b0, 3'(4 + ($random(seed) & 3)), 1'b0, 3'($random(seed) & 3)};
      wr(spimc_pkg::BAUD_ADDR, b);
    end
    stx = 8'($random(seed));
    exp_q.push_back(8'h5A);
    exp_q.push_back(8'hC3);
    wr(spimc_pkg::DATA_ADDR, 8'h5A);
    wr(spimc_pkg::DATA_ADDR, 8'hC3);
    wait_idle();
    rd(spimc_pkg::DATA_ADDR, d);
    chk("held rx", stx, d);
    rd(spimc_pkg::STATUS_ADDR, d);
    chk("held status", 8'h02, d);
    wr(spimc_pkg::DATA_ADDR, 8'h99);
    repeat (30) @(posedge clock);
    wr(spimc_pkg::BAUD_ADDR, b ^ 8'h10);
    #1 chk("abort idle", 8'h01, {7'h00, ss_out});
    rd(spimc_pkg::STATUS_ADDR, d);
    chk("abort status", 8'h00, d);
    for (a = 0; a < 3; a++)
    begin
      wr(spimc_pkg::CTRL2_ADDR, c2[a]);
      #1 chk("data pin role", oe[a], {7'h00, mosi_oe});
      chk("clock pin role", 8'h01, {7'h00, sck_oe});
    end
    wr(spimc_pkg::CTRL2_ADDR, 8'h10);
    wr(spimc_pkg::MASK_ADDR, 8'h02);
    wr(spimc_pkg::CTRL1_ADDR, 8'h90);
    #1 chk("select input", 8'h00, {7'h00, ss_oe});
    wr(spimc_pkg::DATA_ADDR, 8'h3C);
    repeat (20) @(posedge clock);
    ext_ss <= 1'b0;
    repeat (8) @(posedge clock);
    #1 chk("fault pins", 8'h00, {3'h0, miso_out, miso_oe, sck_oe, mosi_oe, ss_oe});
    chk("fault idle", 8'h01, {7'h00, ss_out});
    chk("masked irq", 8'h00, {7'h00, irq});
    wr(spimc_pkg::MASK_ADDR, 8'h03);
    #1 chk("fault irq", 8'h01, {7'h00, irq});
    rd(spimc_pkg::CTRL1_ADDR, d);
    chk("master cleared", 8'h80, d);
    rd(spimc_pkg::STATUS_ADDR, d);
    chk("fault flag", 8'h01, d);
    ext_ss <= 1'b1;
    rd(spimc_pkg::STATUS_ADDR, d);
    chk("flag cleared", 8'h00, d);
    chk("bytes left", 8'h00, 8'(exp_q.size()));
    results();
  end
endmodule : testbench
